//--- cie_pkg.sv
// package: op codes, instruction carrier and constants of the execute unit
// ------------------------------------------------------------------
// Contract
// - register add, with carry, one clock
// - word immediate add/subtract takes two clocks
// - constant minus carry, one clock
// - and/or/xor one clock, carry kept
// - mask clear uses 0xFF minus constant
// - 8x8 products into R1:R0, two clocks
// - fractional products shifted left by one
// - pointer jump loads pc from Z
// - pointer call pushes return, three clocks
// - compare skip equal, one to three clocks
// - io bit skip, one to three clocks
// - flag branch to pc+k+1 when true
// - signed branches test negative xor overflow
// - compares update flags, write nothing
// - indirect load two clocks, pointer modes
// - indirect write two clocks, pointer modes
// - direct load and write two clocks
// - program memory read via Z, three clocks
// - push and pop take two clocks
// - io bit set/clear only 0x00-0x1F
// - read-modify-write clears any set w1c flag
// - rotate right through carry, one clock
// ------------------------------------------------------------------
package cie_pkg;
    // operation codes of the decoded instruction
    typedef enum logic [5:0] {
        OP_NOP = 6'h00, OP_ADD = 6'h01, OP_ADDC = 6'h02, OP_SUB = 6'h03,
        OP_SUBC = 6'h04, OP_AND = 6'h05, OP_OR = 6'h06, OP_XOR = 6'h07,
        OP_MASK_CLEAR = 6'h08, OP_CMP = 6'h09, OP_CMPC = 6'h0A,
        OP_WORD_PLUS = 6'h0B, OP_WORD_MINUS = 6'h0C, OP_PRODUCT = 6'h0D,
        OP_PTR_JUMP = 6'h0E, OP_PTR_CALL = 6'h0F, OP_CMP_SKIP = 6'h10,
        OP_IO_SKIP_SET = 6'h11, OP_IO_SKIP_CLR = 6'h12,
        OP_FLAG_BR_SET = 6'h13, OP_FLAG_BR_CLR = 6'h14,
        OP_IND_LOAD = 6'h15, OP_IND_WRITE = 6'h16, OP_DIR_LOAD = 6'h17,
        OP_DIR_WRITE = 6'h18, OP_PM_FETCH = 6'h19, OP_PUSH = 6'h1A,
        OP_POP = 6'h1B, OP_IO_RAISE = 6'h1C, OP_IO_LOWER = 6'h1D,
        OP_ROT_RIGHT = 6'h1E, OP_RETURN = 6'h1F, OP_INT_RESUME = 6'h20
    } cie_op_e;

    // decoded instruction carrier
    typedef struct packed {
        cie_op_e     op;        // operation
        logic [4:0]  rd;        // destination / first operand
        logic [4:0]  rr;        // second operand / store source
        logic        imm_en;    // second operand is k
        logic [7:0]  k;         // constant or signed branch offset
        logic [15:0] addr;      // direct data address
        logic [2:0]  bit_sel;   // io bit or flag bit
        logic [5:0]  io_addr;   // io register address
        logic [1:0]  ptr_sel;   // X, Y or Z
        logic [1:0]  ptr_mode;  // plain, post-inc, pre-dec, displacement
        logic [5:0]  disp;      // displacement q
        logic        sgn_d;     // rd signed in products
        logic        sgn_r;     // rr signed in products
        logic        frac;      // fractional product
        logic        next_two;  // following instruction is two words
        logic        dst_r0;    // program read without destination
    } cie_instr_s;

    localparam logic [4:0]  REG_R0 = 5'h00;
    localparam logic [4:0]  REG_R1 = 5'h01;
    localparam logic [4:0]  REG_X = 5'h1A;
    localparam logic [4:0]  REG_Y = 5'h1C;
    localparam logic [4:0]  REG_Z = 5'h1E;
    localparam logic [1:0]  PTR_X = 2'h0;
    localparam logic [1:0]  PTR_Y = 2'h1;
    localparam logic [1:0]  AM_POST = 2'h1;
    localparam logic [1:0]  AM_PRE = 2'h2;
    localparam logic [1:0]  AM_DISP = 2'h3;
    localparam int          FL_C = 0, FL_Z = 1, FL_N = 2, FL_V = 3;
    localparam int          FL_S = 4, FL_H = 5, FL_I = 7;
    localparam logic [5:0]  IO_BIT_MAX = 6'h1F;
    localparam logic [7:0]  FULL_BYTE = 8'hFF;
    localparam logic [7:0]  FLAGS_RST = 8'h00;
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [15:0] SP_RST = 16'h0000;
    localparam logic [2:0]  CYC_ONE = 3'h1, CYC_WORD = 3'h2, CYC_PRODUCT = 3'h2;
    localparam logic [2:0]  CYC_PJUMP = 3'h2, CYC_PCALL = 3'h3, CYC_SKIP1 = 3'h2;
    localparam logic [2:0]  CYC_SKIP2 = 3'h3, CYC_BR_TAKEN = 3'h2, CYC_MEM = 3'h2;
    localparam logic [2:0]  CYC_PMF = 3'h3, CYC_STACK = 3'h2, CYC_IOBIT = 3'h2;
    localparam logic [2:0]  CYC_RETURN = 3'h4;
endpackage : cie_pkg

//--- cie_exec.sv
// execute unit: registers, flags, pc, stack and memory strobes
`timescale 1ns/1ps
module cie_exec
    import cie_pkg::*;
#(
    parameter logic [15:0] SP_RESET = SP_RST  // stack pointer after reset
) (
    input  wire logic        core_clk,      // system clock
    input  wire logic        reset,         // synchronous, active high
    input  wire logic        instr_valid,   // decoded instruction offered
    input  wire cie_instr_s  instr,         // decoded instruction
    output logic             instr_ready,   // taken when valid and ready
    output logic [15:0]      pc,            // word address of instruction
    output logic [7:0]       status_flags,  // flag byte I T H S V N Z C
    output logic [15:0]      stack_ptr,     // stack pointer
    output logic [15:0]      dm_addr,       // data memory address
    output logic [7:0]       dm_wdata,      // data memory write byte
    output logic             dm_we,         // data memory write strobe
    output logic             dm_re,         // data memory read strobe
    input  wire logic [7:0]  dm_rdata,      // read byte, one cycle later
    output logic [5:0]       io_addr,       // io register address
    output logic [7:0]       io_wdata,      // io write byte
    output logic             io_we,         // io write strobe
    output logic             io_re,         // io read strobe
    input  wire logic [7:0]  io_rdata,      // io read byte, same cycle
    output logic [15:0]      pmf_addr,      // program memory word address
    output logic             pmf_re,        // program memory read strobe
    input  wire logic [15:0] pmf_rdata      // program word, one cycle later
);
    // ------------------------------------------------------------------
    // state and working signals
    // ------------------------------------------------------------------
    logic [7:0]        rf_q [32];       // general register file
    logic [7:0]        flags_q, flags_d; // status flag byte
    logic [15:0]       pc_q, pc_d;      // program counter
    logic [15:0]       sp_q, sp_d;      // stack pointer
    logic              busy_q;          // multi-cycle op in flight
    logic [2:0]        cnt_q, cyc, len; // cycle number and op length
    cie_instr_s        cur_q, cur;      // held and current instruction
    logic              go, fin;         // active cycle, last cycle
    logic              cond_q, cond_live, cond; // skip/branch decision
    logic [7:0]        tmp_q, hi_q;     // captured bytes
    logic [7:0]        a, rv, b, res;   // alu operands and result
    logic              cin, hc, vf, cf, zf;
    logic [8:0]        sum9;
    logic [4:0]        pb;              // pointer pair low index
    logic [15:0]       pv, pea, pnew;   // pointer, address, new pointer
    logic [15:0]       wv, wres, pr, ret_addr;
    logic [8:0]        a9, b9;
    logic signed [17:0] prod;
    logic [7:0]        bmask;
    logic              is_bit;

    // ------------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------------
    assign cur         = busy_q ? cur_q : instr;
    assign cyc         = busy_q ? cnt_q : CYC_ONE;
    assign go          = busy_q | instr_valid;
    assign instr_ready = ~busy_q;
    assign fin         = go & (cyc == len);
    assign cond        = (cyc == CYC_ONE) ? cond_live : cond_q;
    assign a           = rf_q[cur.rd];
    assign rv          = rf_q[cur.rr];
    assign b           = cur.imm_en ? cur.k : rv;
    assign ret_addr    = pc_q + 16'h0001;
    assign is_bit      = (cur.op == OP_IO_RAISE) | (cur.op == OP_IO_LOWER);
    assign bmask       = 8'h01 << cur.bit_sel;

    // hold the instruction and count its cycles
    always_ff @(posedge core_clk) begin
        if (reset) begin
            busy_q <= 1'b0;
            cnt_q  <= 3'h0;
            cur_q  <= '0;
            cond_q <= 1'b0;
        end else if (go) begin
            if (cyc == CYC_ONE) cond_q <= cond_live;
            cur_q  <= cur;
            busy_q <= ~fin;
            cnt_q  <= cyc + 3'h1;
        end
    end

    // skip and branch decision, frozen after the first cycle
    always_comb begin
        case (cur.op)
            OP_CMP_SKIP:    cond_live = (a == rv);
            OP_IO_SKIP_SET: cond_live = io_rdata[cur.bit_sel];
            OP_IO_SKIP_CLR: cond_live = ~io_rdata[cur.bit_sel];
            OP_FLAG_BR_SET: cond_live = flags_q[cur.bit_sel];
            OP_FLAG_BR_CLR: cond_live = ~flags_q[cur.bit_sel];
            default:        cond_live = 1'b0;
        endcase
    end

    // length of the current operation in clocks
    always_comb begin
        case (cur.op)
            OP_WORD_PLUS, OP_WORD_MINUS: len = CYC_WORD;
            OP_PRODUCT:  len = CYC_PRODUCT;
            OP_PTR_JUMP: len = CYC_PJUMP;
            OP_PTR_CALL: len = CYC_PCALL;
            OP_CMP_SKIP, OP_IO_SKIP_SET, OP_IO_SKIP_CLR:
                len = !cond ? CYC_ONE : (cur.next_two ? CYC_SKIP2 : CYC_SKIP1);
            OP_FLAG_BR_SET, OP_FLAG_BR_CLR: len = cond ? CYC_BR_TAKEN : CYC_ONE;
            OP_IND_LOAD, OP_IND_WRITE, OP_DIR_LOAD, OP_DIR_WRITE: len = CYC_MEM;
            OP_PM_FETCH: len = CYC_PMF;
            OP_PUSH, OP_POP: len = CYC_STACK;
            OP_IO_RAISE, OP_IO_LOWER: len = CYC_IOBIT;
            OP_RETURN, OP_INT_RESUME: len = CYC_RETURN;
            default:     len = CYC_ONE;
        endcase
    end

    // ------------------------------------------------------------------
    // pointers, word and product datapath
    // ------------------------------------------------------------------
    // pointer pair selection and addressing modes
    always_comb begin
        case (cur.ptr_sel)
            PTR_X:   pb = REG_X;
            PTR_Y:   pb = REG_Y;
            default: pb = REG_Z;
        endcase
        if (cur.op == OP_PM_FETCH || cur.op == OP_PTR_JUMP || cur.op == OP_PTR_CALL) begin
            pb = REG_Z;
        end
        pv = {rf_q[pb + 5'h01], rf_q[pb]};
        case (cur.ptr_mode)
            AM_PRE:  pea = pv - 16'h0001;
            AM_DISP: pea = pv + {10'h000, cur.disp};
            default: pea = pv;
        endcase
        case (cur.ptr_mode)
            AM_POST: pnew = pv + 16'h0001;
            AM_PRE:  pnew = pv - 16'h0001;
            default: pnew = pv;
        endcase
    end

    // word plus or minus a constant
    assign wv   = {rf_q[cur.rd + 5'h01], a};
    assign wres = (cur.op == OP_WORD_PLUS) ? wv + {8'h00, cur.k} : wv - {8'h00, cur.k};

    // sign-extend per operand, 9x9 signed product
    assign a9   = {cur.sgn_d & a[7], a};
    assign b9   = {cur.sgn_r & rv[7], rv};
    assign prod = $signed(a9) * $signed(b9);
    // fractional form shifts left by one
    assign pr   = cur.frac ? {prod[14:0], 1'b0} : prod[15:0];

    // ------------------------------------------------------------------
    // byte alu
    // ------------------------------------------------------------------
    always_comb begin
        cin  = 1'b0;
        sum9 = 9'h000;
        res  = a;
        hc   = flags_q[FL_H];
        vf   = 1'b0;
        cf   = flags_q[FL_C];
        case (cur.op)
            OP_ADD, OP_ADDC: begin
                cin  = (cur.op == OP_ADDC) & flags_q[FL_C];
                sum9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
                res  = sum9[7:0];
                cf   = sum9[8];
                hc   = (a[3] & b[3]) | (b[3] & ~res[3]) | (~res[3] & a[3]);
                vf   = (a[7] & b[7] & ~res[7]) | (~a[7] & ~b[7] & res[7]);
            end
            OP_SUB, OP_SUBC, OP_CMP, OP_CMPC: begin
                cin  = ((cur.op == OP_SUBC) | (cur.op == OP_CMPC)) & flags_q[FL_C];
                sum9 = {1'b0, a} - {1'b0, b} - {8'h00, cin};
                res  = sum9[7:0];
                cf   = sum9[8];
                hc   = (~a[3] & b[3]) | (b[3] & res[3]) | (res[3] & ~a[3]);
                vf   = (a[7] & ~b[7] & ~res[7]) | (~a[7] & b[7] & res[7]);
            end
            // logic ops clear overflow, keep carry
            OP_AND: res = a & b;
            OP_OR:  res = a | b;
            OP_XOR: res = a ^ b;
            // clear the bits set in k
            OP_MASK_CLEAR: res = a & (FULL_BYTE - cur.k);
            // carry into bit 7, bit 0 out to carry
            OP_ROT_RIGHT: begin
                res = {flags_q[FL_C], a[7:1]};
                cf  = a[0];
                vf  = res[7] ^ a[0];
            end
            default: ;
        endcase
        // chained zero for multi-byte subtract and compare
        zf = (res == 8'h00) & (((cur.op != OP_SUBC) & (cur.op != OP_CMPC)) | flags_q[FL_Z]);
    end

    // ------------------------------------------------------------------
    // flag, pc and stack pointer next values
    // ------------------------------------------------------------------
    always_comb begin
        flags_d = flags_q;
        case (cur.op)
            OP_ADD, OP_ADDC, OP_SUB, OP_SUBC, OP_CMP, OP_CMPC, OP_AND, OP_OR,
            OP_XOR, OP_MASK_CLEAR, OP_ROT_RIGHT: begin
                flags_d[FL_H] = hc;
                flags_d[FL_C] = cf;
                flags_d[FL_V] = vf;
                flags_d[FL_N] = res[7];
                flags_d[FL_Z] = zf;
                // sign flag is negative xor overflow
                flags_d[FL_S] = res[7] ^ vf;
            end
            OP_WORD_PLUS, OP_WORD_MINUS: begin
                flags_d[FL_V] = (cur.op == OP_WORD_PLUS) ? ~wv[15] & wres[15] : wv[15] & ~wres[15];
                flags_d[FL_C] = (cur.op == OP_WORD_PLUS) ? wv[15] & ~wres[15] : ~wv[15] & wres[15];
                flags_d[FL_N] = wres[15];
                flags_d[FL_Z] = (wres == 16'h0000);
                flags_d[FL_S] = wres[15] ^ flags_d[FL_V];
            end
            // products touch zero and carry only
            OP_PRODUCT: begin
                flags_d[FL_C] = prod[15];
                flags_d[FL_Z] = (pr == 16'h0000);
            end
            OP_INT_RESUME: flags_d[FL_I] = 1'b1;
            default: ;
        endcase
    end

    always_comb begin
        pc_d = ret_addr;
        sp_d = sp_q;
        case (cur.op)
            OP_CMP_SKIP, OP_IO_SKIP_SET, OP_IO_SKIP_CLR:
                if (cond) pc_d = pc_q + (cur.next_two ? 16'h0003 : 16'h0002);
            OP_FLAG_BR_SET, OP_FLAG_BR_CLR:
                if (cond) pc_d = ret_addr + {{8{cur.k[7]}}, cur.k};
            OP_PTR_JUMP: pc_d = pv;
            // call target from Z, two bytes pushed
            OP_PTR_CALL: begin
                pc_d = pv;
                sp_d = sp_q - 16'h0002;
            end
            OP_DIR_LOAD, OP_DIR_WRITE: pc_d = pc_q + 16'h0002;
            OP_PUSH: sp_d = sp_q - 16'h0001;
            OP_POP:  sp_d = sp_q + 16'h0001;
            OP_RETURN, OP_INT_RESUME: begin
                pc_d = {hi_q, tmp_q};
                sp_d = sp_q + 16'h0002;
            end
            default: ;
        endcase
    end

    // ------------------------------------------------------------------
    // memory, io and program memory strobes
    // ------------------------------------------------------------------
    always_comb begin
        dm_addr  = 16'h0000;
        dm_wdata = 8'h00;
        dm_we    = 1'b0;
        dm_re    = 1'b0;
        if (go && cyc == CYC_ONE) begin
            case (cur.op)
                OP_IND_LOAD: begin dm_re = 1'b1; dm_addr = pea; end
                OP_IND_WRITE: begin dm_we = 1'b1; dm_addr = pea; dm_wdata = rv; end
                OP_DIR_LOAD: begin dm_re = 1'b1; dm_addr = cur.addr; end
                OP_DIR_WRITE: begin dm_we = 1'b1; dm_addr = cur.addr; dm_wdata = rv; end
                // push writes at sp, pop reads sp+1
                OP_PUSH: begin dm_we = 1'b1; dm_addr = sp_q; dm_wdata = rv; end
                OP_POP: begin dm_re = 1'b1; dm_addr = sp_q + 16'h0001; end
                OP_PTR_CALL: begin dm_we = 1'b1; dm_addr = sp_q; dm_wdata = ret_addr[7:0]; end
                OP_RETURN, OP_INT_RESUME: begin dm_re = 1'b1; dm_addr = sp_q + 16'h0001; end
                default: ;
            endcase
        end else if (go && cyc == 3'h2) begin
            case (cur.op)
                OP_PTR_CALL: begin
                    dm_we    = 1'b1;
                    dm_addr  = sp_q - 16'h0001;
                    dm_wdata = ret_addr[15:8];
                end
                OP_RETURN, OP_INT_RESUME: begin dm_re = 1'b1; dm_addr = sp_q + 16'h0002; end
                default: ;
            endcase
        end
    end

    // io reads for bit tests, write-back for bit set and clear
    assign io_addr  = cur.io_addr;
    assign io_re    = go & (cyc == CYC_ONE) & (is_bit | (cur.op == OP_IO_SKIP_SET) |
                      (cur.op == OP_IO_SKIP_CLR));
    // whole register written back, low 32 addresses only
    assign io_we    = go & (cyc == 3'h2) & is_bit & (cur.io_addr <= IO_BIT_MAX);
    // set w1c flags are written back as ones and clear
    assign io_wdata = (cur.op == OP_IO_RAISE) ? tmp_q | bmask : tmp_q & ~bmask;
    // word address from Z, byte chosen by Z bit 0
    assign pmf_re   = go & (cyc == CYC_ONE) & (cur.op == OP_PM_FETCH);
    assign pmf_addr = {1'b0, pv[15:1]};

    // capture bytes that later cycles consume
    always_ff @(posedge core_clk) begin
        if (reset) begin
            tmp_q <= 8'h00;
            hi_q  <= 8'h00;
        end else if (go) begin
            if (cyc == CYC_ONE && is_bit) tmp_q <= io_rdata;
            if (cyc == 3'h2 && cur.op == OP_PM_FETCH) tmp_q <= pv[0] ? pmf_rdata[15:8] : pmf_rdata[7:0];
            if (cyc == 3'h2 && (cur.op == OP_RETURN || cur.op == OP_INT_RESUME)) hi_q <= dm_rdata;
            if (cyc == 3'h3 && (cur.op == OP_RETURN || cur.op == OP_INT_RESUME)) tmp_q <= dm_rdata;
        end
    end

    // ------------------------------------------------------------------
    // architectural state
    // ------------------------------------------------------------------
    // register file writes at the last cycle of each op
    always_ff @(posedge core_clk) begin
        if (reset) begin
            for (int i = 0; i < 32; i++) rf_q[i] <= 8'h00;
        end else if (fin) begin
            case (cur.op)
                // alu result written back, compares excluded
                OP_ADD, OP_ADDC, OP_SUB, OP_SUBC, OP_AND, OP_OR, OP_XOR,
                OP_MASK_CLEAR, OP_ROT_RIGHT: rf_q[cur.rd] <= res;
                OP_WORD_PLUS, OP_WORD_MINUS: begin
                    rf_q[cur.rd]         <= wres[7:0];
                    rf_q[cur.rd + 5'h01] <= wres[15:8];
                end
                OP_PRODUCT: begin
                    rf_q[REG_R0] <= pr[7:0];
                    rf_q[REG_R1] <= pr[15:8];
                end
                OP_IND_LOAD, OP_DIR_LOAD, OP_POP: rf_q[cur.rd] <= dm_rdata;
                OP_PM_FETCH: rf_q[cur.dst_r0 ? REG_R0 : cur.rd] <= tmp_q;
                default: ;
            endcase
            // pointer update after or before the access
            if ((cur.op == OP_IND_LOAD || cur.op == OP_IND_WRITE || cur.op == OP_PM_FETCH) &&
                (cur.ptr_mode == AM_POST || cur.ptr_mode == AM_PRE)) begin
                rf_q[pb]         <= pnew[7:0];
                rf_q[pb + 5'h01] <= pnew[15:8];
            end
        end
    end

    // flags, pc and stack pointer commit together
    always_ff @(posedge core_clk) begin
        if (reset) begin
            flags_q <= FLAGS_RST;
            pc_q    <= PC_RST;
            sp_q    <= SP_RESET;
        end else if (fin) begin
            flags_q <= flags_d;
            pc_q    <= pc_d;
            sp_q    <= sp_d;
        end
    end

    assign pc           = pc_q;
    assign status_flags = flags_q;
    assign stack_ptr    = sp_q;
endmodule : cie_exec

//--- cie_exec_asserts.sv
// checker: busy lengths, strobes and flag relations of the execute unit
`timescale 1ns/1ps
module cie_exec_asserts import cie_pkg::*; (
    input wire logic       core_clk, reset, instr_valid, instr_ready, io_re, io_we, pmf_re,
    input wire cie_instr_s instr,
    input wire logic [7:0] status_flags
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // take of one instruction, then a two-step busy tail
    sequence s_go(c); instr_valid && instr_ready && c; endsequence
    sequence s_wait2; !instr_ready ##1 instr_ready; endsequence
    property p_one; s_go(instr.op inside {OP_ADD, OP_AND, OP_SUBC}) |=> instr_ready; endproperty
    a_one: assert property (p_one) else $error("single op stalled");
    property p_two; s_go(instr.op inside {OP_DIR_LOAD, OP_PRODUCT, OP_PUSH, OP_PTR_JUMP})
        |=> s_wait2; endproperty
    a_two: assert property (p_two) else $error("two clock op length");
    property p_three; s_go(instr.op == OP_PM_FETCH) |-> pmf_re ##1 !instr_ready ##1 s_wait2;
    endproperty
    a_three: assert property (p_three) else $error("program read length");
    property p_four; s_go(instr.op == OP_RETURN) |=> !instr_ready[*2] ##1 s_wait2; endproperty
    a_four: assert property (p_four) else $error("return length");
    property p_keepc; s_go(instr.op inside {OP_AND, OP_MASK_CLEAR})
        |=> status_flags[FL_C] == $past(status_flags[FL_C]); endproperty
    a_keepc: assert property (p_keepc) else $error("carry changed by logic op");
    property p_calm; s_go(instr.op inside {OP_DIR_WRITE, OP_PUSH}) |=> $stable(status_flags)[*2];
    endproperty
    a_calm: assert property (p_calm) else $error("flags moved by transfer");
    property p_iobit; s_go(instr.op == OP_IO_RAISE)
        |-> io_re ##1 (io_we == ($past(instr.io_addr) <= IO_BIT_MAX)); endproperty
    a_iobit: assert property (p_iobit) else $error("io bit write strobe");
    property p_brno; s_go(instr.op == OP_FLAG_BR_CLR && status_flags[instr.bit_sel])
        |=> instr_ready; endproperty
    a_brno: assert property (p_brno) else $error("untaken branch stalled");
    property p_bryes; s_go(instr.op == OP_FLAG_BR_SET && status_flags[instr.bit_sel])
        |=> s_wait2; endproperty
    a_bryes: assert property (p_bryes) else $error("taken branch length");
endmodule : cie_exec_asserts
bind cie_exec cie_exec_asserts chk_u (.*);

//--- cie_mem.sv
// partner: data memory, io space and program memory of the execute unit
`timescale 1ns/1ps
module cie_mem (
    input  wire logic        core_clk, dm_we, dm_re, io_we, pmf_re,
    input  wire logic [15:0] dm_addr, pmf_addr,
    input  wire logic [7:0]  dm_wdata, io_wdata,
    input  wire logic [5:0]  io_addr,
    output logic      [7:0]  dm_rdata, io_rdata,
    output logic      [15:0] pmf_rdata
);
    logic [7:0] dm [256];  // data bytes, low address byte decoded
    logic [7:0] io [64];   // io registers
    initial begin
        foreach (dm[i]) dm[i] = 8'h00;
        foreach (io[i]) io[i] = 8'h00;
        dm_rdata = 8'h00;
        pmf_rdata = 16'h0000;
    end
    assign io_rdata = io[io_addr];
    // reads answer one clock later; idle lines toggle so stale data never matches
    always @(posedge core_clk) begin
        dm_rdata <= dm_re ? dm[dm_addr[7:0]] : ~dm_rdata;
        pmf_rdata <= pmf_re ? {pmf_addr[7:0], 8'h5A} : ~pmf_rdata;
        if (dm_we) dm[dm_addr[7:0]] <= dm_wdata;
        if (io_we) io[io_addr] <= io_wdata;
    end
endmodule : cie_mem

//--- tb_top.sv
// testbench: offers decoded instructions, checks length, pc, flags and memory
`timescale 1ns/1ps
module tb_top import cie_pkg::*;;
    logic       core_clk = 1'b0, reset = 1'b1, instr_valid = 1'b0;
    cie_instr_s instr = '0;
    logic       instr_ready, dm_we, dm_re, io_we, io_re, pmf_re;
    logic [15:0] pc, stack_ptr, dm_addr, pmf_addr, pmf_rdata;
    logic [7:0] status_flags, dm_wdata, dm_rdata, io_wdata, io_rdata;
    logic [5:0] io_addr;
    int         n_mismatch = 0, checks = 0;
    cie_exec dut_u (.*);
    cie_mem mem_u (.*);
    always #12.5 core_clk = ~core_clk;
    task automatic chk(input logic [15:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    // offer one instruction, count its clocks including the first, then compare count, pc and flags
    task automatic run(input cie_op_e op, input logic [4:0] rd, rr, input logic [7:0] k,
                       input int nc, input logic [15:0] npc, input logic [7:0] fl);
        cie_instr_s i;
        int         n;
        i = '0; i.op = op; i.rd = rd; i.rr = rr; i.k = k; i.addr = {8'h00, k};
        i.imm_en = op inside {OP_AND, OP_SUBC, OP_MASK_CLEAR};
        i.bit_sel = rr[2:0]; i.io_addr = k[5:0]; i.dst_r0 = 1'b1;
        @(posedge core_clk) instr <= i;
        instr_valid <= 1'b1;
        @(posedge core_clk) instr_valid <= 1'b0;
        n = 1;
        #1;
        while (instr_ready !== 1'b1 && n < 9) begin
            @(posedge core_clk) #1;
            n++;
        end
        if (n == 9) begin
            n_mismatch++;
            tally_and_finish();
        end
        chk(16'(n), 16'(nc));
        chk(pc, npc);
        chk({8'h00, status_flags}, {8'h00, fl});
        $display("done %h", op);
    endtask : run
    initial begin
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        mem_u.dm[16] = 8'h3C; mem_u.dm[17] = 8'hC5; mem_u.io[5] = 8'h81;
        run(OP_DIR_LOAD, 5'h10, 5'h00, 8'h10, 2, 16'h0002, 8'h00);
        run(OP_DIR_LOAD, 5'h11, 5'h00, 8'h11, 2, 16'h0004, 8'h00);
        run(OP_ADD, 5'h10, 5'h11, 8'h00, 1, 16'h0005, 8'h21);
        run(OP_AND, 5'h11, 5'h00, 8'h0F, 1, 16'h0006, 8'h21);
        run(OP_MASK_CLEAR, 5'h10, 5'h00, 8'h01, 1, 16'h0007, 8'h23);
        run(OP_SUBC, 5'h11, 5'h00, 8'h06, 1, 16'h0008, 8'h35);
        run(OP_DIR_WRITE, 5'h00, 5'h11, 8'h20, 2, 16'h000A, 8'h35);
        chk({8'h00, mem_u.dm[32]}, 16'h00FE);
        run(OP_FLAG_BR_SET, 5'h00, 5'h02, 8'h05, 2, 16'h0010, 8'h35);
        run(OP_FLAG_BR_CLR, 5'h00, 5'h04, 8'h05, 1, 16'h0011, 8'h35);
        run(OP_PRODUCT, 5'h11, 5'h11, 8'h00, 2, 16'h0012, 8'h35);
        run(OP_PUSH, 5'h00, 5'h00, 8'h00, 2, 16'h0013, 8'h35);
        run(OP_PUSH, 5'h00, 5'h01, 8'h00, 2, 16'h0014, 8'h35);
        chk({mem_u.dm[255], mem_u.dm[0]}, 16'hFC04);
        chk(stack_ptr, 16'hFFFE);
        run(OP_IO_RAISE, 5'h00, 5'h03, 8'h05, 2, 16'h0015, 8'h35);
        chk({8'h00, mem_u.io[5]}, 16'h0089);
        run(OP_IO_RAISE, 5'h00, 5'h03, 8'h20, 2, 16'h0016, 8'h35);
        chk({8'h00, mem_u.io[32]}, 16'h0000);
        run(OP_IO_SKIP_SET, 5'h00, 5'h03, 8'h05, 2, 16'h0018, 8'h35);
        run(OP_PM_FETCH, 5'h00, 5'h00, 8'h00, 3, 16'h0019, 8'h35);
        run(OP_RETURN, 5'h00, 5'h00, 8'h00, 4, 16'hFC04, 8'h35);
        run(OP_PTR_JUMP, 5'h00, 5'h00, 8'h00, 2, 16'h0000, 8'h35);
        run(OP_ROT_RIGHT, 5'h11, 5'h00, 8'h00, 1, 16'h0001, 8'h2C);
        run(OP_CMP_SKIP, 5'h10, 5'h02, 8'h00, 2, 16'h0003, 8'h2C);
        run(OP_CMP, 5'h11, 5'h10, 8'h00, 1, 16'h0004, 8'h14);
        run(OP_WORD_PLUS, 5'h11, 5'h00, 8'h01, 2, 16'h0005, 8'h00);
        run(OP_PTR_CALL, 5'h00, 5'h00, 8'h00, 3, 16'h0000, 8'h00);
        chk(stack_ptr, 16'hFFFE);
        chk({mem_u.dm[255], mem_u.dm[0]}, 16'h0006);
        tally_and_finish();
    end
endmodule : tb_top
